// [inc/cro_pkg.sv]
/*
  constants for the calibration / ring threshold / overload control register.
  assumes a byte-wide host port with one-cycle read and write strobes on clk.
*/
// Overview of operation
// RQ1: calibration-clear bit high makes the device discard stored calibration data.
// RQ2: host must write calibration-clear back to zero for normal operation.
// RQ3: writing one to manual calibration bit starts a calibration.
// RQ4: auto-calibration runs when disable bit is zero, suppressed when one.
// RQ5: companion bit plus high select choose ring threshold: 00, 10, 11.
// RQ6: host must never program companion zero with high select one.
// RQ7: host should clear overload protect before going off-hook.
// RQ8: billing tone enable lets device detect tones and hold off-hook.
// RQ9: device sets read-only billing tone flag when tone is detected.
// RQ10: writing zero to billing tone enable also clears billing tone flag.
// RQ11: device sets receive overload flag on excessive receive level.
// RQ12: writing zero to overload flag clears it and the interrupt copy.
// RQ13: writing one to overload flag never sets it.
`default_nettype none
package cro_pkg;
  localparam logic [7:0] REG_ADDR     = 8'h11; // calibration_ring_overload_control
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [7:0] RD_EMPTY     = 8'h00; // read data at reset and for unmapped addresses
  localparam int         BIT_CLR_CAL  = 7;
  localparam int         BIT_MAN_CAL  = 6;
  localparam int         BIT_ACAL_DIS = 5;
  localparam int         BIT_RT_HIGH  = 4;
  localparam int         BIT_OVL_PROT = 3;
  localparam int         BIT_BT_EN    = 2;
  localparam int         BIT_RX_OVL   = 1;
  localparam int         BIT_BT_FLAG  = 0;
  typedef enum logic [1:0] {THR_LOW, THR_MID, THR_HIGH, THR_RSVD} cro_thresh_t;
endpackage : cro_pkg
`default_nettype wire

// [logic/cro_event_flag.sv]
/*
  sticky event flag: set by a hardware event, cleared by a write strobe.
  assumes event and clear are synchronous to clk; set wins over clear.
*/
`default_nettype none
module cro_event_flag (
  input  wire logic clk,      // system clock
  input  wire logic rstn,     // sync reset, active low
  input  wire logic ce,       // clock enable
  input  wire logic setEvt,   // hardware event
  input  wire logic clr,      // software clear
  output var  logic flag      // sticky flag
);
  logic next_flag;

  // set dominates so an event in the clear cycle is kept
  always_comb
  begin
    next_flag = flag;
    if (clr)
      next_flag = 1'b0;
    if (setEvt)
      next_flag = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      flag <= 1'b0;
    else if (ce)
      flag <= next_flag;
  end
endmodule : cro_event_flag
`default_nettype wire

// [logic/cro_ctrl_reg.sv]
/*
  control/status register at offset 0x11: calibration controls, ring threshold
  high select, overload protect, billing tone enable and the two event flags.
  assumes host strobes on clk; detector event inputs come from analog pins.
*/
`default_nettype none
module cro_ctrl_reg (
  input  wire logic       clk,            // 20 MHz system clock
  input  wire logic       rstn,           // sync reset, active low
  input  wire logic       ce,             // clock enable, freezes all state
  input  wire logic [7:0] addr,           // register address
  input  wire logic       wrEn,           // write strobe
  input  wire logic       rdEn,           // read strobe
  input  wire logic [7:0] wrData,         // write data
  output var  logic [7:0] rdData,         // read data, valid the cycle after rdEn
  input  wire logic       ringThreshSel,  // companion threshold bit from neighbour register
  input  wire logic       rxOverloadPin,  // async receive overload detector
  input  wire logic       billTonePin,    // async billing tone detector
  output var  logic       clearCalData,   // discard calibration data
  output var  logic       manualCalStart, // one-cycle manual calibration start
  output var  logic       autocalEn,      // automatic calibration allowed
  output var  logic [1:0] ringThresh,     // selected threshold pair
  output var  logic       overloadProtEn, // overload protection enable
  output var  logic       billToneEn,     // billing tone detection active
  output var  logic       rxOvlIrqClr     // pulse clearing interrupt-register copy
);
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [1:0] ovlSync;
  logic [1:0] btSync;
  logic       rxOverloadFlag;
  logic       billToneFlag;
  logic       hit;
  logic       ovlClr;
  logic       btClr;
  logic       btSet;
  logic [7:0] next_rdData;
  logic       next_manualCalStart;
  logic       next_rxOvlIrqClr;
  logic [1:0] next_ringThresh;

  assign hit = (addr == cro_pkg::REG_ADDR);

  // two-stage synchronisers for analog detector outputs
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ovlSync <= 2'h0;
      btSync  <= 2'h0;
    end
    else if (ce)
    begin
      ovlSync <= {ovlSync[0], rxOverloadPin};
      btSync  <= {btSync[0], billTonePin};
    end
  end

  // clears: overload on written zero only; a written one has no effect
  assign ovlClr = ce & wrEn & hit & ~wrData[cro_pkg::BIT_RX_OVL];  // RQ12 RQ13
  assign btClr  = ce & wrEn & hit & ~wrData[cro_pkg::BIT_BT_EN];   // RQ10
  // tone only counted while detection is enabled
  assign btSet  = ce & btSync[1] & ctrl[cro_pkg::BIT_BT_EN];      // RQ8 RQ9

  cro_event_flag u_ovl (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (ce),
    .setEvt (ce & ovlSync[1]),  // RQ11
    .clr    (ovlClr),
    .flag   (rxOverloadFlag)
  );

  cro_event_flag u_bt (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (ce),
    .setEvt (btSet),
    .clr    (btClr),
    .flag   (billToneFlag)
  );

  // writable control bits; bits 1:0 live in the flag cells
  always_comb
  begin
    next_ctrl = ctrl;
    if (wrEn && hit)
    begin
      next_ctrl = wrData;
      next_ctrl[cro_pkg::BIT_MAN_CAL] = 1'b0; // start is self-clearing
      next_ctrl[cro_pkg::BIT_RX_OVL]  = 1'b0;
      next_ctrl[cro_pkg::BIT_BT_FLAG] = 1'b0;
    end
  end

  // registered outputs, derived from next state so they track the register
  always_comb
  begin
    next_manualCalStart = wrEn & hit & wrData[cro_pkg::BIT_MAN_CAL];  // RQ3
    next_rxOvlIrqClr    = wrEn & hit & ~wrData[cro_pkg::BIT_RX_OVL];  // RQ12
    // reserved code 01 is not guarded: host keeps it out, decoded as low
    unique case ({ringThreshSel, next_ctrl[cro_pkg::BIT_RT_HIGH]})    // RQ5 RQ6
      2'b10:   next_ringThresh = cro_pkg::THR_MID;
      2'b11:   next_ringThresh = cro_pkg::THR_HIGH;
      default: next_ringThresh = cro_pkg::THR_LOW;
    endcase
    next_rdData = rdData;
    // ctrl keeps its two flag positions at zero, so the flag cells fill them in
    if (rdEn && hit)
    begin
      next_rdData = ctrl;
      next_rdData[cro_pkg::BIT_RX_OVL]  = rxOverloadFlag;
      next_rdData[cro_pkg::BIT_BT_FLAG] = billToneFlag;
    end
    else if (rdEn)
      next_rdData = cro_pkg::RD_EMPTY; // unmapped reads return zero
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl           <= cro_pkg::REG_RESET;
      rdData         <= cro_pkg::RD_EMPTY;
      clearCalData   <= 1'b0;
      manualCalStart <= 1'b0;
      autocalEn      <= ~cro_pkg::REG_RESET[cro_pkg::BIT_ACAL_DIS];
      ringThresh     <= cro_pkg::THR_LOW;
      overloadProtEn <= 1'b0;
      billToneEn     <= 1'b0;
      rxOvlIrqClr    <= 1'b0;
    end
    else if (ce)
    begin
      ctrl           <= next_ctrl;
      rdData         <= next_rdData;
      clearCalData   <= next_ctrl[cro_pkg::BIT_CLR_CAL];   // RQ1 RQ2
      manualCalStart <= next_manualCalStart;
      autocalEn      <= ~next_ctrl[cro_pkg::BIT_ACAL_DIS]; // RQ4
      ringThresh     <= next_ringThresh;
      overloadProtEn <= next_ctrl[cro_pkg::BIT_OVL_PROT];  // RQ7
      billToneEn     <= next_ctrl[cro_pkg::BIT_BT_EN];     // RQ8
      rxOvlIrqClr    <= next_rxOvlIrqClr;
    end
  end

  // sequence: a zero written to bit 1 with no overload in flight
  sequence s_ovl_clear;
    ce && wrEn && hit && !wrData[cro_pkg::BIT_RX_OVL] && !ovlSync[1];
  endsequence

  // sequence: a zero written to the billing tone enable bit
  sequence s_bt_off_write;
    ce && wrEn && hit && !wrData[cro_pkg::BIT_BT_EN];
  endsequence

  // sequence: a one written to the manual calibration bit
  sequence s_manual_cal_start_req;
    ce && wrEn && hit && wrData[cro_pkg::BIT_MAN_CAL];
  endsequence

  // sequence: start pulse is up and no new start is being written
  sequence s_manual_cal_start_idle;
    ce && manualCalStart && !(wrEn && hit && wrData[cro_pkg::BIT_MAN_CAL]);
  endsequence


  AST_OVL_CLEAR: assert property (@(posedge clk) disable iff (!rstn) // RQ12
    s_ovl_clear |=> !rxOverloadFlag && rxOvlIrqClr)
    else $error("overload flag not cleared by zero write");
  AST_OVL_SET: assert property (@(posedge clk) disable iff (!rstn) // RQ11
    ce && ovlSync[1] |=> rxOverloadFlag)
    else $error("overload event lost");
  AST_OVL_NOSET: assert property (@(posedge clk) disable iff (!rstn) // RQ13
    ce && !rxOverloadFlag && !ovlSync[1] |=> !rxOverloadFlag)
    else $error("overload flag set without event");
  AST_BT_CLEAR: assert property (@(posedge clk) disable iff (!rstn) // RQ10
    s_bt_off_write |=> !billToneEn && (billToneFlag == $past(btSet)))
    else $error("tone flag not cleared");
  AST_BT_SET: assert property (@(posedge clk) disable iff (!rstn) // RQ9
    btSet |=> billToneFlag)
    else $error("tone flag not set");
  AST_BT_GATE: assert property (@(posedge clk) disable iff (!rstn) // RQ8
    $rose(billToneFlag) |-> $past(ctrl[cro_pkg::BIT_BT_EN]))
    else $error("tone flag set while disabled");
  // start is a pulse: raised by the write, dropped unless another start follows
  AST_MANUAL_CAL_START: assert property (@(posedge clk) disable iff (!rstn) // RQ3
    s_manual_cal_start_req |=> manualCalStart)
    else $error("manual calibration start missing");
  AST_MANUAL_CAL_START_END: assert property (@(posedge clk) disable iff (!rstn) // RQ3
    s_manual_cal_start_idle |=> !manualCalStart)
    else $error("manual calibration start too long");
  AST_CLEAR_CAL_DATA: assert property (@(posedge clk) disable iff (!rstn) // RQ1
    ce && wrEn && hit |=> clearCalData == $past(wrData[cro_pkg::BIT_CLR_CAL]))
    else $error("calibration clear not following register");
  AST_ACAL: assert property (@(posedge clk) disable iff (!rstn) // RQ4
    ce && wrEn && hit |=> autocalEn == !$past(wrData[cro_pkg::BIT_ACAL_DIS]))
    else $error("auto calibration enable mismatch");
  AST_THR: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    ce && ctrl[cro_pkg::BIT_RT_HIGH] && $stable(ringThreshSel) && ringThreshSel && !(wrEn && hit)
      |=> ringThresh == cro_pkg::THR_HIGH)
    else $error("threshold decode wrong");

  // middle and low codes; the reserved code falls back to low
  AST_THR_MID: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    ce && !ctrl[cro_pkg::BIT_RT_HIGH] && ringThreshSel && !(wrEn && hit) |=> ringThresh == cro_pkg::THR_MID)
    else $error("middle threshold decode wrong");
  AST_THR_LOW: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    ce && !ringThreshSel && !(wrEn && hit) |=> ringThresh == cro_pkg::THR_LOW)
    else $error("low threshold decode wrong");

  // interrupt-copy clear is one pulse per zero write, never a level
  AST_IRQCLR_END: assert property (@(posedge clk) disable iff (!rstn) // RQ12
    ce && rxOvlIrqClr && !(wrEn && hit && !wrData[cro_pkg::BIT_RX_OVL]) |=> !rxOvlIrqClr)
    else $error("interrupt clear pulse too long");

  // both flags must reach the host exactly as they stood at the read strobe
  AST_RD_FLAGS: assert property (@(posedge clk) disable iff (!rstn) // RQ9 RQ11
    ce && rdEn && hit |=> rdData[cro_pkg::BIT_RX_OVL] == $past(rxOverloadFlag)
      && rdData[cro_pkg::BIT_BT_FLAG] == $past(billToneFlag))
    else $error("flags not returned on read");

  // unmapped reads must not leak the previous read value
  AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!rstn)
    ce && rdEn && !hit |=> rdData == cro_pkg::RD_EMPTY)
    else $error("unmapped read returned data");

  // clock enable low freezes register, read data and both flags
  AST_CE_FREEZE: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(ctrl) && $stable(rdData) && $stable(rxOverloadFlag) && $stable(billToneFlag))
    else $error("state moved with clock enable low");
endmodule : cro_ctrl_reg
`default_nettype wire

// [verification/cal_ring_overload_ctrl_test.sv]
/*
  self-checking bench for the control/status register at offset 0x11.
  assumes cro_ctrl_reg as the design; the bench drives every port itself.
*/
`default_nettype none
module cal_ring_overload_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rstn, ce, wrEn, rdEn, ringThreshSel, rxOverloadPin, billTonePin;
  logic [7:0] addr, wrData, rdData;
  logic       clearCalData, manualCalStart, autocalEn, overloadProtEn, billToneEn, rxOvlIrqClr;
  logic [1:0] ringThresh;
  int         errorCnt, totalChecks;

  cro_ctrl_reg dut_u (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wrEn(wrEn), .rdEn(rdEn),
    .wrData(wrData), .rdData(rdData), .ringThreshSel(ringThreshSel), .rxOverloadPin(rxOverloadPin),
    .billTonePin(billTonePin), .clearCalData(clearCalData), .manualCalStart(manualCalStart),
    .autocalEn(autocalEn), .ringThresh(ringThresh), .overloadProtEn(overloadProtEn),
    .billToneEn(billToneEn), .rxOvlIrqClr(rxOvlIrqClr));

  // 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // all control outputs packed as clr,man,acal,thr[1:0],ope,bte,irqclr
  function automatic logic [7:0] outs();
    return {clearCalData, manualCalStart, autocalEn, ringThresh, overloadProtEn, billToneEn, rxOvlIrqClr};
  endfunction : outs

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    totalChecks++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // write strobe held one cycle; returns in the cycle the effects show
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    @(negedge clk);
    wrEn = 1'b0;
  endtask : wrReg

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    addr = a;
    rdEn = 1'b1;
    @(negedge clk);
    rdEn = 1'b0;
    chk(rdData, exp, what);
  endtask : rdChk

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrapUp

  // main sequence; every input changes at the falling edge only
  initial
  begin
    {rstn, ce, wrEn, rdEn, ringThreshSel, rxOverloadPin, billTonePin} = 7'h20;
    addr = 8'h00;
    wrData = 8'h00;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    chk(outs(), 8'h20, "reset outputs");
    rdChk(cro_pkg::REG_ADDR, cro_pkg::REG_RESET, "reset value");
    $display("test reset done");
    wrReg(cro_pkg::REG_ADDR, 8'h80);
    chk(outs(), 8'ha1, "clear cal set");
    rdChk(cro_pkg::REG_ADDR, 8'h80, "clear cal readback");
    wrReg(cro_pkg::REG_ADDR, 8'h00);
    chk(outs(), 8'h21, "clear cal released");
    wrReg(cro_pkg::REG_ADDR, 8'h40);
    chk(outs(), 8'h61, "manual cal pulse");
    @(negedge clk);
    chk(outs(), 8'h20, "manual cal pulse ends");
    rdChk(cro_pkg::REG_ADDR, 8'h00, "manual cal self clears");
    wrReg(cro_pkg::REG_ADDR, 8'h20);
    chk(outs(), 8'h01, "autocal suppressed");
    $display("test calibration done");
    // only the three legal threshold codes are programmed
    for (int i = 0; i < 3; i++)
    begin
      ringThreshSel = (i > 0);
      wrReg(cro_pkg::REG_ADDR, (i == 2) ? 8'h10 : 8'h00);
      @(negedge clk);
      chk({6'h00, ringThresh}, i[7:0], "threshold pair");
    end
    // high select is cleared before the companion bit drops, so code 01 never shows
    wrReg(cro_pkg::REG_ADDR, 8'h08);
    ringThreshSel = 1'b0;
    @(negedge clk);
    chk(outs(), 8'h24, "overload protect");
    $display("test threshold done");
    wrReg(cro_pkg::REG_ADDR, 8'h04);
    @(negedge clk);
    chk(outs(), 8'h22, "billing enable");
    billTonePin = 1'b1;
    repeat (4) @(negedge clk);
    billTonePin = 1'b0;
    rdChk(cro_pkg::REG_ADDR, 8'h05, "billing flag set");
    wrReg(cro_pkg::REG_ADDR, 8'h00);
    rdChk(cro_pkg::REG_ADDR, 8'h00, "billing flag cleared");
    billTonePin = 1'b1;
    repeat (4) @(negedge clk);
    billTonePin = 1'b0;
    rdChk(cro_pkg::REG_ADDR, 8'h00, "no tone flag while disabled");
    $display("test billing done");
    rxOverloadPin = 1'b1;
    repeat (4) @(negedge clk);
    rdChk(cro_pkg::REG_ADDR, 8'h02, "overload flag set");
    // a clear while the event still stands must lose to the event
    wrReg(cro_pkg::REG_ADDR, 8'h00);
    rdChk(cro_pkg::REG_ADDR, 8'h02, "event beats clear");
    rxOverloadPin = 1'b0;
    wrReg(cro_pkg::REG_ADDR, 8'h02);
    chk({7'h00, rxOvlIrqClr}, 8'h00, "no irq clear on one");
    rdChk(cro_pkg::REG_ADDR, 8'h02, "overload flag kept");
    wrReg(cro_pkg::REG_ADDR, 8'h00);
    chk({7'h00, rxOvlIrqClr}, 8'h01, "irq clear pulse");
    rdChk(cro_pkg::REG_ADDR, 8'h00, "overload flag cleared");
    wrReg(cro_pkg::REG_ADDR, 8'h03);
    rdChk(cro_pkg::REG_ADDR, 8'h00, "flags not writable");
    $display("test overload done");
    // stray address and frozen clock enable must leave the register alone
    wrReg(8'h12, 8'hff);
    rdChk(cro_pkg::REG_ADDR, 8'h00, "stray write ignored");
    // a nonzero read first, so a stale value cannot pass as the unmapped answer
    wrReg(cro_pkg::REG_ADDR, 8'h08);
    rdChk(cro_pkg::REG_ADDR, 8'h08, "overload protect readback");
    rdChk(8'h12, 8'h00, "unmapped read");
    ce = 1'b0;
    wrReg(cro_pkg::REG_ADDR, 8'h80);
    ce = 1'b1;
    chk(outs(), 8'h24, "outputs frozen with ce low");
    rdChk(cro_pkg::REG_ADDR, 8'h08, "write with ce low");
    $display("test access done");
    // reset from a non-reset state must bring every output back
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk(outs(), 8'h20, "mid-run reset outputs");
    rdChk(cro_pkg::REG_ADDR, cro_pkg::REG_RESET, "mid-run reset value");
    $display("test mid-run reset done");
    wrapUp();
  end

  // tests need about 100 cycles; cut a hang well after that
  initial
  begin
    repeat (3000) @(posedge clk);
    errorCnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrapUp();
  end
endmodule : cal_ring_overload_ctrl_test
`default_nettype wire
